// ### rtl/tmirq_core.sv
// Functional notes
// - Six enable registers, reset and standby to 0x40
// - Enable bit 7 triggers conversion on A events
// - Bit 6 of both registers reads 1
// - Bit 5 gates underflow; reserved in ch0/3
// - Enable bit 4 gates overflow request
// - Bit 3 gates D event in ch0/3 only
// - Bit 2 gates C event in ch0/3 only
// - Enable bit 1 gates B event request
// - Enable bit 0 gates A event request
// - Six status registers, reset and standby to 0xC0
// - Flags clear by writing 0 after reading 1
// - Status bit 7 shows direction in ch1/2/4/5
// - Underflow flag sets on 0x0000 to 0xFFFF
// - Underflow clears by 0 after reading 1
// - Overflow flag sets on 0xFFFF to 0x0000
// - Overflow clears by 0 after reading 1
// - Status bit 3 flags D event in ch0/3
// - General flag sets on compare or capture
// - Transfer-controller service also clears general flags
`include "tmirq_regs.svh"

module tmirq_core
  import tmirq_pkg::*;
#(
  parameter int NCH = 6
) (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  input  wire logic              i_hw_standby,
  // Events from the timer datapath, same clock
  input  wire tmirq_evt_t [5:0]  i_evt,
  input  wire logic       [5:0]  i_count_up,
  // Transfer controller service acknowledge per flag and its disable-select
  input  wire tmirq_evt_t [5:0]  i_xfer_ack,
  input  wire logic       [5:0]  i_xfer_disable_sel,
  // AXI4-Lite slave
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic       [7:0]  s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic       [31:0] s_axi_wdata,
  input  wire logic       [3:0]  s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic            [1:0]  s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic       [7:0]  s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic            [31:0] s_axi_rdata,
  output logic            [1:0]  s_axi_rresp,
  // Requests
  output tmirq_irq_t      [5:0]  o_irq,
  output logic            [5:0]  o_adc_start
);

  // Channels 0 and 3 own four general registers
  function automatic logic four_gen(input int ch);
    return (ch == 0) || (ch == 3);
  endfunction

  // Enable bits that software may change in one channel; the rest are fixed
  function automatic logic [7:0] ier_wmask(input int ch);
    return four_gen(ch) ? `TMIRQ_IER_WMASK_4G : `TMIRQ_IER_WMASK_2G;
  endfunction

  // Flag bits that exist in one channel, in unf,ovf,d,c,b,a order
  function automatic logic [5:0] flag_mask(input int ch);
    logic [7:0] m;
    m = four_gen(ch) ? `TMIRQ_SR_FMASK_4G : `TMIRQ_SR_FMASK_2G;
    return m[5:0];
  endfunction

  // Event struct flattened into flag order; shared by events and services
  function automatic logic [5:0] evt_bits(input tmirq_evt_t e);
    return {e.unf, e.ovf, e.gen_d, e.gen_c, e.gen_b, e.gen_a};
  endfunction

  // Decode an address into channel, register select and validity
  function automatic logic [4:0] dec_addr(input logic [7:0] a);
    logic [2:0] ch;
    ch = 3'(a[7:3]);
    dec_addr = {(a[1:0] == 2'b00) && (a <= `TMIRQ_ADDR_TOP), a[2], ch};
  endfunction

  // Status read value assembled from flags and fixed bits.
  // Bits that do not exist in a channel read as constants, so software
  // can treat every status register alike and mask what it needs.
  // Bit 6 is always 1; bit 7 is the live direction only where the
  // channel can count down, and a constant 1 elsewhere.
  // Status read value assembled from flags and fixed bits
  function automatic logic [7:0] sr_view(input int ch, input logic [5:0] f,
                                         input logic up);
    logic [7:0] v;
    v = 8'h00;
    v[`TMIRQ_B_RSV6] = 1'b1;
    v[`TMIRQ_B_OVF]  = f[4];
    v[`TMIRQ_B_GENB] = f[1];
    v[`TMIRQ_B_GENA] = f[0];
    if (four_gen(ch)) begin
      v[`TMIRQ_B_DIR]  = 1'b1;
      v[`TMIRQ_B_GEND] = f[3];
      v[`TMIRQ_B_GENC] = f[2];
    end else begin
      v[`TMIRQ_B_DIR] = up;
      v[`TMIRQ_B_UNF] = f[5];
    end
    return v;
  endfunction

  tmirq_state_t s_q;
  tmirq_state_t s_d;
  logic [5:0]   up_q;

  // Direction flag is live datapath state; register it for reads.
  // The one-cycle lag only matters to a read racing a direction change,
  // which software cannot order against the counter anyway.
  // Direction flag is live datapath state; register it for reads
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_hw_standby) begin
      up_q <= '1;
    end else if (i_ce) begin
      up_q <= i_count_up;
    end
  end

  // Bus timing seen from the master:
  //  - write address and write data are taken in either order, each
  //    while its ready is high and nothing else is pending;
  //  - the write lands on the edge after both are held, and bvalid
  //    rises on that same edge;
  //  - bvalid and bresp stand until the edge that samples bready high;
  //  - a read is taken while arready is high; rvalid, rdata and rresp
  //    rise on the next edge and stand until rready is sampled high.
  // Ready outputs are gated by the clock enable, so no transfer is taken
  // in a frozen cycle and none can be lost.
  // Unmapped or unaligned addresses answer with a slave error and touch
  // nothing; a write without byte lane 0 is accepted and ignored.

  // Next-state logic: bus handshakes, register writes, flag set and clear
  always_comb begin
    logic [5:0] xa;
    logic [4:0] wd;
    logic [4:0] rd;
    logic       do_wr;
    logic       do_rd;
    logic [5:0] evv;
    logic [5:0] clr;
    logic [7:0] wm;
    logic [5:0] fm;
    wd    = dec_addr(s_q.awaddr);
    rd    = dec_addr(s_axi_araddr);
    do_wr = 1'b0;
    do_rd = 1'b0;
    evv   = '0;
    clr   = '0;
    wm    = '0;
    fm    = '0;
    xa    = '0;
    s_d   = s_q;
    s_d.adc_trig = '0;

    // Write address and data captured in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got  = 1'b1;
      s_d.wdata  = s_axi_wdata[7:0];
      s_d.wstrb0 = s_axi_wstrb[0];
    end
    unique case (s_q.wst)
      TMIRQ_WR_IDLE: begin
        if (s_q.aw_got && s_q.w_got) begin
          do_wr      = s_q.wstrb0 && wd[4];
          s_d.bresp  = wd[4] ? 2'b00 : 2'b10;
          s_d.wst    = TMIRQ_WR_RESP;
          s_d.aw_got = 1'b0;
          s_d.w_got  = 1'b0;
        end
      end
      TMIRQ_WR_RESP: begin
        if (s_axi_bready) begin
          s_d.wst = TMIRQ_WR_IDLE;
        end
      end
      default: s_d.wst = TMIRQ_WR_IDLE;
    endcase

    // Read: one-cycle decode, registered data.
    // The read data register is loaded in the cycle the address is taken
    // and then held, so a slow rready sees a stable word. A status read
    // also arms the clear of every flag it returned as 1.
    // Read: one-cycle decode, registered data
    unique case (s_q.rst)
      TMIRQ_RD_IDLE: begin
        if (s_axi_arvalid) begin
          do_rd     = rd[4];
          s_d.rresp = rd[4] ? 2'b00 : 2'b10;
          s_d.rdata = '0;
          s_d.rst   = TMIRQ_RD_RESP;
        end
      end
      TMIRQ_RD_RESP: begin
        if (s_axi_rready) begin
          s_d.rst = TMIRQ_RD_IDLE;
        end
      end
      default: s_d.rst = TMIRQ_RD_IDLE;
    endcase

    // Per-channel flag protocol:
    //  - an event pulse sets its flag on the next edge;
    //  - a status read returning 1 arms that flag's clear;
    //  - a later 0 written to an armed flag clears it; a 1 does nothing;
    //  - a fresh set disarms, so a clear cannot swallow an event that
    //    software has not yet seen;
    //  - a transfer-controller service clears a general flag directly,
    //    unless its disable-select is high;
    //  - when a set and a clear meet in one cycle the set wins.
    // Events for flags that do not exist in a channel are masked off.
    for (int ch = 0; ch < NCH; ch++) begin
      wm  = ier_wmask(ch);
      fm  = flag_mask(ch);
      evv = evt_bits(i_evt[ch]) & fm;
      xa  = evt_bits(i_xfer_ack[ch]);
      clr = '0;
      // Reading a flag as 1 arms its clear
      if (do_rd && rd[2:0] == 3'(ch)) begin
        if (rd[3]) begin
          s_d.rdata = {24'h000000, sr_view(ch, s_q.flag[ch], up_q[ch])};
          s_d.armed[ch] = s_q.armed[ch] | s_q.flag[ch];
        end else begin
          s_d.rdata = {24'h000000, s_q.ier[ch] | `TMIRQ_IER_RESET};
        end
      end
      if (do_wr && wd[2:0] == 3'(ch)) begin
        if (wd[3]) begin
          // Zero written to an armed flag clears it; one leaves it alone
          clr = ~{s_q.wdata[`TMIRQ_B_UNF], s_q.wdata[`TMIRQ_B_OVF],
                  s_q.wdata[3:0]} & s_q.armed[ch] & fm;
        end else begin
          s_d.ier[ch] = (s_q.wdata & wm) | `TMIRQ_IER_RESET;
        end
      end
      // Transfer controller service clears general flags when not disabled
      if (!i_xfer_disable_sel[ch]) begin
        clr[3:0] = clr[3:0] | (xa[3:0] & fm[3:0]);
      end
      // Set wins over clear in the same cycle
      s_d.flag[ch]  = (s_q.flag[ch] & ~clr) | evv;
      s_d.armed[ch] = s_d.armed[ch] & ~clr & ~evv;
      s_d.adc_trig[ch] = s_q.ier[ch][`TMIRQ_B_TRIG] && i_evt[ch].gen_a;
    end
  end

  // State register; reset and standby load the reset values.
  // Both act regardless of the clock enable, so a frozen block still
  // comes out of reset or standby clean. Flags and arms clear to 0,
  // which with the fixed bits gives status 0xC0; enables load 0x40.
  // Any pending bus response is dropped; the master must not keep a
  // transfer open across reset.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_hw_standby) begin
      s_q       <= '0;
      for (int ch = 0; ch < NCH; ch++) begin
        s_q.ier[ch] <= `TMIRQ_IER_RESET;
      end
      s_q.wst   <= TMIRQ_WR_IDLE;
      s_q.rst   <= TMIRQ_RD_IDLE;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  // Bus handshake outputs.
  // Ready signals are combinational from state and the clock enable;
  // valid, data and response signals all come straight from flip-flops.
  // Address and data readies drop as soon as their half is held, which
  // keeps the master from offering a second write before the first ends.
  // The conversion start is a one-cycle registered pulse, one cycle
  // after the general register A event that caused it.
  // Bus handshake outputs
  assign s_axi_awready = !s_q.aw_got && (s_q.wst == TMIRQ_WR_IDLE) && i_ce;
  assign s_axi_wready  = !s_q.w_got && (s_q.wst == TMIRQ_WR_IDLE) && i_ce;
  assign s_axi_bvalid  = (s_q.wst == TMIRQ_WR_RESP);
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = (s_q.rst == TMIRQ_RD_IDLE) && i_ce;
  assign s_axi_rvalid  = (s_q.rst == TMIRQ_RD_RESP);
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign o_adc_start   = s_q.adc_trig;

  // Request levels: flag AND enable.
  // These are levels, not pulses: a request stands while both bits are 1
  // and drops on the edge that clears either, so the interrupt side needs
  // no edge detection. Bits absent in a channel are held at 0 in both
  // registers, so their requests can never rise.
  // Request levels: flag AND enable
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_irq
      assign o_irq[g].underflow_irq = s_q.flag[g][5] && s_q.ier[g][`TMIRQ_B_UNF];
      assign o_irq[g].overflow_irq  = s_q.flag[g][4] && s_q.ier[g][`TMIRQ_B_OVF];
      assign o_irq[g].gen_d_irq     = s_q.flag[g][3] && s_q.ier[g][`TMIRQ_B_GEND];
      assign o_irq[g].gen_c_irq     = s_q.flag[g][2] && s_q.ier[g][`TMIRQ_B_GENC];
      assign o_irq[g].gen_b_irq     = s_q.flag[g][1] && s_q.ier[g][`TMIRQ_B_GENB];
      assign o_irq[g].gen_a_irq     = s_q.flag[g][0] && s_q.ier[g][`TMIRQ_B_GENA];
    end
  endgenerate

endmodule // tmirq_core

// ### rtl/tmirq_regs.svh
`ifndef TMIRQ_REGS_SVH
`define TMIRQ_REGS_SVH

// Register byte offsets: enable at 0x00 + 8*ch, status at 0x04 + 8*ch
`define TMIRQ_IER_BASE   8'h00
`define TMIRQ_SR_BASE    8'h04
`define TMIRQ_CH_STRIDE  8'h08
`define TMIRQ_ADDR_TOP   8'h2F

// Reset values
`define TMIRQ_IER_RESET  8'h40
`define TMIRQ_SR_RESET   8'hC0

// Field positions
`define TMIRQ_B_TRIG     7
`define TMIRQ_B_DIR      7
`define TMIRQ_B_RSV6     6
`define TMIRQ_B_UNF      5
`define TMIRQ_B_OVF      4
`define TMIRQ_B_GEND     3
`define TMIRQ_B_GENC     2
`define TMIRQ_B_GENB     1
`define TMIRQ_B_GENA     0

// Writable enable bits per channel kind (four-register vs two-register)
`define TMIRQ_IER_WMASK_4G 8'h9F
`define TMIRQ_IER_WMASK_2G 8'hB3
// Clearable flag bits per channel kind
`define TMIRQ_SR_FMASK_4G  8'h1F
`define TMIRQ_SR_FMASK_2G  8'h33

`endif

// ### rtl/tmirq_pkg.sv
package tmirq_pkg;

  // Per-channel events from the counter and general-register datapath
  typedef struct packed {
    logic unf;   // Counter stepped 0x0000 -> 0xFFFF
    logic ovf;   // Counter wrapped 0xFFFF -> 0x0000
    logic gen_d; // Compare match or capture on general register D
    logic gen_c; // Compare match or capture on general register C
    logic gen_b; // Compare match or capture on general register B
    logic gen_a; // Compare match or capture on general register A
  } tmirq_evt_t;

  // Per-channel interrupt request levels
  typedef struct packed {
    logic underflow_irq;
    logic overflow_irq;
    logic gen_d_irq;
    logic gen_c_irq;
    logic gen_b_irq;
    logic gen_a_irq;
  } tmirq_irq_t;

  typedef enum logic [1:0] {
    TMIRQ_WR_IDLE,
    TMIRQ_WR_RESP
  } tmirq_wr_st_t;

  typedef enum logic [1:0] {
    TMIRQ_RD_IDLE,
    TMIRQ_RD_RESP
  } tmirq_rd_st_t;

  // State of the block except the registered direction flags
  typedef struct packed {
    logic [5:0][7:0] ier;       // Enable registers
    logic [5:0][5:0] flag;      // unf,ovf,d,c,b,a flags
    logic [5:0][5:0] armed;     // Flag read as 1 since last set/clear
    logic [5:0]      adc_trig;  // One-cycle conversion start requests
    tmirq_wr_st_t    wst;
    tmirq_rd_st_t    rst;
    logic            aw_got;
    logic            w_got;
    logic [7:0]      awaddr;
    logic [7:0]      wdata;
    logic            wstrb0;
    logic [1:0]      bresp;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } tmirq_state_t;

endpackage

// ### sim/tmirq_core_sva.sv
module tmirq_core_sva
  import tmirq_pkg::*;
(
  input wire logic             i_clk,
  input wire logic             i_sys_rst,
  input wire logic             i_hw_standby,
  input wire tmirq_evt_t [5:0] i_evt,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_rvalid,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire tmirq_irq_t [5:0] o_irq,
  input wire logic [5:0]       o_adc_start
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Requests tied to their causes, and fixed bits of read data
  property p_rst_quiet; $fell(i_sys_rst) |-> o_irq == '0 && o_adc_start == '0; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("request after reset");
  property p_stby; i_hw_standby |=> o_irq == '0 && o_adc_start == '0; endproperty
  a_stby: assert property (p_stby) else $error("request after standby");
  property p_adc; o_adc_start[0] |-> $past(i_evt[0].gen_a); endproperty
  a_adc: assert property (p_adc) else $error("stray conversion start");
  property p_ovf_up;
    $rose(o_irq[0].overflow_irq) |-> $past(i_evt[0].ovf) || s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_ovf_up: assert property (p_ovf_up) else $error("overflow request without cause");
  property p_ovf_dn;
    $fell(o_irq[0].overflow_irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(i_hw_standby);
  endproperty
  a_ovf_dn: assert property (p_ovf_dn) else $error("overflow request lost");
  property p_no_unf; !o_irq[0].underflow_irq && !o_irq[3].underflow_irq; endproperty
  a_no_unf: assert property (p_no_unf) else $error("underflow request in ch0 or ch3");
  property p_no_cd; !o_irq[1].gen_c_irq && !o_irq[4].gen_d_irq; endproperty
  a_no_cd: assert property (p_no_cd) else $error("C or D request in two-register ch");
  property p_rd; s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6];
  endproperty
  a_rd: assert property (p_rd) else $error("fixed read bits wrong");
endmodule // tmirq_core_sva

bind tmirq_core tmirq_core_sva u_sva (.*);

// ### sim/tmirq_xfer_model.sv
module tmirq_xfer_model
  import tmirq_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_en,
  input  wire logic [1:0]       i_dly,
  input  wire tmirq_irq_t [5:0] i_irq,
  output tmirq_evt_t      [5:0] o_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q;
  // Serve pending A-D requests after a chosen wait, one-cycle acknowledge
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_en) begin
      wait_q <= 2'h0;
      o_ack  <= '0;
    end else if ((i_irq & {6{6'h0F}}) != '0 && o_ack == '0) begin
      if (wait_q == i_dly) begin
        o_ack  <= i_irq & {6{6'h0F}};
        wait_q <= 2'h0;
      end else begin
        o_ack  <= '0;
        wait_q <= wait_q + 2'h1;
      end
    end else begin
      o_ack <= '0;
    end
  end
endmodule // tmirq_xfer_model

// ### sim/tmirq_core_tb.sv
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
$display("mismatch %s exp %0h got %0h", n, e, a); end end
module tmirq_core_tb
  import tmirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             i_clk = '0, i_sys_rst = '1, i_ce = '1, i_hw_standby = '0, xen = '0;
  logic             s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic             s_axi_arvalid = '0, s_axi_rready = '0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]       s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]      s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]       s_axi_wstrb = 4'hF;
  logic [1:0]       s_axi_bresp, s_axi_rresp, dly = '0;
  logic [5:0]       i_count_up = '0, i_xfer_disable_sel = '0, o_adc_start;
  tmirq_evt_t [5:0] i_evt = '0, i_xfer_ack;
  tmirq_irq_t [5:0] o_irq;
  int               miscompares = 0, comparisons = 0, ier[6], fl[6], arm[6];
  tmirq_core DUT (.*);
  tmirq_xfer_model u_xfer (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(xen), .i_dly(dly),
    .i_irq(o_irq), .o_ack(i_xfer_ack));
  // 100 MHz clock
  initial forever #5 i_clk = ~i_clk;
  // Reference register image
  function automatic int exp_rd(int a);
    if (a % 8) return (a / 8 % 3 ? i_count_up[a / 8] << 7 : 'h80) | 'h40 | fl[a / 8];
    return ier[a / 8];
  endfunction
  task automatic mreset();
    foreach (ier[c]) begin ier[c] = 'h40; fl[c] = 0; arm[c] = 0; end
  endtask
  task automatic wr(int a, int d);
    int t = 0, c = a / 8, clr;
    logic ga, gw, gb;
    logic [1:0] rs;
    @(posedge i_clk);
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    s_axi_awaddr <= 8'(a);
    s_axi_wdata <= 32'(d);
    do begin
      @(negedge i_clk);
      ga = s_axi_awready & s_axi_awvalid;
      gw = s_axi_wready & s_axi_wvalid;
      gb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge i_clk);
      if (ga) s_axi_awvalid <= '0;
      if (gw) s_axi_wvalid <= '0;
      t++;
    end while (!gb && t < 40);
    if (!gb) miscompares++;
    s_axi_bready <= '0;
    `CHK("bresp", a > 'h2F ? 2 : 0, rs)
    if (a > 'h2F) return;
    if (a % 8 == 0) ier[c] = 'h40 | d & (c % 3 ? 'hB3 : 'h9F);
    else begin clr = arm[c] & ~d & 'h3F; fl[c] &= ~clr; arm[c] &= ~clr; end
  endtask
  task automatic rd(int a);
    int t = 0;
    logic ga, gr;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge i_clk);
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    s_axi_araddr <= 8'(a);
    do begin
      @(negedge i_clk);
      ga = s_axi_arready & s_axi_arvalid;
      gr = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge i_clk);
      if (ga) s_axi_arvalid <= '0;
      t++;
    end while (!gr && t < 40);
    if (!gr) miscompares++;
    s_axi_rready <= '0;
    `CHK("rresp", a > 'h2F ? 2 : 0, rs)
    if (a > 'h2F) return;
    `CHK("rdata", exp_rd(a), d)
    if (a % 8) arm[a / 8] |= fl[a / 8];
  endtask
  task automatic rdall();
    for (int a = 0; a <= 'h30; a += 4) rd(a);
  endtask
  task automatic wrall(int st, int d);
    for (int c = 0; c < 6; c++) wr(8 * c + st, d < 0 ? $urandom : d);
    wr('h30, 0);
  endtask
  task automatic chk();
    @(negedge i_clk);
    for (int c = 0; c < 6; c++) `CHK("irq", 6'(fl[c] & ier[c]), o_irq[c])
  endtask
  task automatic pulse();
    int e[6];
    @(posedge i_clk);
    for (int c = 0; c < 6; c++) begin
      e[c] = $urandom;
      i_evt[c] <= 6'(e[c]);
      e[c] &= c % 3 ? 'h33 : 'h1F;
      fl[c] |= e[c];
      arm[c] &= ~e[c];
    end
    @(posedge i_clk);
    i_evt <= '0;
    @(negedge i_clk);
    for (int c = 0; c < 6; c++) `CHK("adc", e[c] & ier[c] >> 7 & 1, o_adc_start[c])
    chk();
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h1325));
    repeat (8) @(posedge i_clk);
    i_sys_rst <= '0;
    i_count_up <= 6'($urandom);
    mreset();
    rdall();
    for (int k = 0; k < 2; k++) begin
      wrall(0, k ? -1 : 'hFF);
      wrall(4, 'hFF);
      repeat (3) pulse();
      wrall(4, 0);
      rdall();
      wrall(4, -1);
      chk();
      rdall();
    end
    dly <= 2'($urandom);
    i_xfer_disable_sel <= 6'($urandom);
    wrall(0, 'h0F);
    pulse();
    xen <= '1;
    repeat (12) @(posedge i_clk);
    foreach (fl[c]) if (!i_xfer_disable_sel[c]) fl[c] &= ~(ier[c] & 'h0F);
    foreach (fl[c]) arm[c] &= fl[c];
    chk();
    rdall();
    xen <= '0;
    @(posedge i_clk) i_hw_standby <= '1;
    @(posedge i_clk) i_hw_standby <= '0;
    mreset();
    rdall();
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
endmodule // tmirq_core_tb
